// file: rtl/fault_supervisor_pkg.sv
package fault_supervisor_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ             = 25000;
  localparam int TICK_MS             = 100;
  localparam int TICK_CYCLES_DEFAULT = CLK_KHZ * TICK_MS / 1;
  localparam int TICKS_PER_MIN       = 60 * 1000 / TICK_MS;
  localparam int TRIP_WINDOW_MIN     = 5;
  localparam int OH_LOCK_MIN         = 10;
  localparam int OL_LOCK_MIN         = 4;
  localparam logic [15:0] WINDOW_TICKS  = 16'(TRIP_WINDOW_MIN * TICKS_PER_MIN);
  localparam logic [15:0] OH_LOCK_TICKS = 16'(OH_LOCK_MIN * TICKS_PER_MIN);
  localparam logic [15:0] OL_LOCK_TICKS = 16'(OL_LOCK_MIN * TICKS_PER_MIN);
  localparam logic [2:0]  OH_TRIP_LIMIT = 3'h3;
  localparam logic [2:0]  OL_TRIP_LIMIT = 3'h4;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          APB_ADDR_W   = 8;
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_OT_CFG  = 8'h04;
  localparam logic [7:0]  ADDR_UT_CFG  = 8'h08;
  localparam logic [7:0]  ADDR_FB_CFG  = 8'h0c;
  localparam logic [7:0]  ADDR_COMM    = 8'h10;
  localparam logic [7:0]  ADDR_SEL     = 8'h14;
  localparam logic [7:0]  ADDR_TERM_LO = 8'h18;
  localparam logic [7:0]  ADDR_TERM_HI = 8'h1c;
  localparam logic [7:0]  ADDR_FAULT   = 8'h20;
  localparam logic [7:0]  ADDR_CODE    = 8'h24;
  localparam logic [7:0]  ADDR_IRQ_ST  = 8'h28;
  localparam logic [7:0]  ADDR_IRQ_CLR = 8'h2c;
  localparam logic [7:0]  ADDR_IRQ_EN  = 8'h30;
  localparam logic [7:0]  ADDR_LOCK    = 8'h34;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RESET_BIT = 0;
  localparam int CFG_LEVEL_LSB  = 0;
  localparam int CFG_TIME_LSB   = 16;
  localparam int SEL_OT_LSB     = 0;
  localparam int SEL_UT_LSB     = 4;
  localparam int SEL_COMM_LSB   = 8;
  localparam int SEL_FB_LSB     = 12;
  localparam int SEL_EXT_LSB    = 16;
  localparam int SEL_STOP_LSB   = 20;
  localparam int TERM_FUNC_W    = 8;

  // ----------------------------------------------------------------
  // Setting values
  // ----------------------------------------------------------------
  localparam logic [3:0] OT_ACTION_FAULT = 4'h0;
  localparam logic [3:0] UT_ACTION_FAULT = 4'h0;
  localparam logic [3:0] COMM_ACTION_MAX = 4'h2;
  localparam logic [3:0] FB_SEL_FAULT    = 4'h2;
  localparam logic [3:0] EXT_SEL_MAX     = 4'h1;
  localparam logic [3:0] STOP_SEL_ON     = 4'h0;
  localparam logic [7:0] FUNC_EXT_FAULT  = 8'h19;
  localparam logic [7:0] FUNC_STOP       = 8'h3a;

  // ----------------------------------------------------------------
  // Fault bits, also the interrupt layout
  // ----------------------------------------------------------------
  localparam int NUM_FAULTS = 14;
  localparam int NUM_TERMS  = 6;
  localparam int FLT_OH     = 0;
  localparam int FLT_OL     = 1;
  localparam int FLT_OT     = 2;
  localparam int FLT_UT     = 3;
  localparam int FLT_COMM   = 4;
  localparam int FLT_FB     = 5;
  localparam int FLT_STOP   = 6;
  localparam int FLT_EXT1   = 7;
  localparam int FLT_MOTOR  = 13;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] SEL_RST  = 32'h0012_0311;
  localparam logic [31:0] TERM_RST = 32'h0000_0000;

endpackage

// file: rtl/persist_if.sv
`timescale 1ns/1ps
interface persist_if;
  logic        tick;
  logic        active;
  logic [15:0] limit;
  logic        expired;
  modport timer (input tick, input active, input limit, output expired);
  modport user  (output tick, output active, output limit, input expired);
endinterface

// file: rtl/persist_timer.sv
`timescale 1ns/1ps
module persist_timer (
  input  wire logic  mclk_in,
  input  wire logic  reset_n_in,
  persist_if.timer   link
);
  typedef struct packed {
    logic [15:0] count;
  } timer_s;

  timer_s s;
  timer_s next_s;

  always_comb begin
    next_s = s;
    if (!link.active) begin
      next_s.count = 16'h0000;
    end else if (link.tick && (s.count < link.limit)) begin
      next_s.count = s.count + 16'h0001;
    end
  end

  // Saturates at the limit so a long fault cannot wrap and re-arm
  assign link.expired = link.active && (s.count >= link.limit);

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule // persist_timer

// file: rtl/drive_fault_supervisor.sv
// Contract
// - Three overheat trips in five minutes block its reset for ten minutes.
// - Four overload trips in five minutes block its reset for four minutes.
// - Over-torque fault when torque stays above level for set time, action 0.
// - Under-torque fault when torque stays below level for set time, action 0.
// - Comm error when no frame within detection time, action 0 to 2.
// - Feedback loss fault when feedback stays below level for time, select 2.
// - Input stop flag when stop select 0 and any terminal function is 58.
// - Each terminal raises its own external fault when its function is 25.
// - Terminal external faults only while external fault select is 0 or 1.
// - Motor switch error when motor change command arrives while running.
`timescale 1ns/1ps
module drive_fault_supervisor #(
  parameter int TICK_CYCLES = fault_supervisor_pkg::TICK_CYCLES_DEFAULT
) (
  input  wire logic                                       mclk_in,
  input  wire logic                                       reset_n_in,
  input  wire logic                                       psel_in,
  input  wire logic                                       penable_in,
  input  wire logic                                       pwrite_in,
  input  wire logic [fault_supervisor_pkg::APB_ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]                                pwdata_in,
  output logic      [31:0]                                prdata_out,
  output logic                                            pready_out,
  output logic                                            pslverr_out,
  input  wire logic                                       heatsink_overheat_in,
  input  wire logic                                       drive_overload_in,
  input  wire logic [15:0]                                torque_in,
  input  wire logic [15:0]                                pid_feedback_in,
  input  wire logic                                       frame_rx_in,
  input  wire logic [fault_supervisor_pkg::NUM_TERMS-1:0] input_terminal_in,
  input  wire logic                                       drive_running_in,
  input  wire logic                                       motor_switch_req_in,
  input  wire logic                                       fault_reset_req_in,
  output logic      [4:0]                                 fault_code_out,
  output logic                                            fault_active_out,
  output logic                                            irq_out
);
  import fault_supervisor_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_TERMS-1:0]  term_meta;
    logic [NUM_TERMS-1:0]  term_sync;
    logic [21:0]           prescale;
    logic                  tick;
    logic [31:0]           ot_cfg;
    logic [31:0]           ut_cfg;
    logic [31:0]           fb_cfg;
    logic [31:0]           comm_cfg;
    logic [31:0]           sel;
    logic [31:0]           term_lo;
    logic [31:0]           term_hi;
    logic [NUM_FAULTS-1:0] fault;
    logic [NUM_FAULTS-1:0] irq_status;
    logic [NUM_FAULTS-1:0] irq_enable;
    logic [4:0]            fault_code;
    logic                  fault_active;
    logic                  irq;
    logic [1:0][2:0]       trip_cnt;
    logic [1:0][15:0]      win_cnt;
    logic [1:0][15:0]      lock_cnt;
    logic [1:0]            locked;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } state_s;

  state_s s;
  state_s next_s;

  localparam logic [1:0][2:0]  TRIP_LIMIT = {OL_TRIP_LIMIT, OH_TRIP_LIMIT};
  localparam logic [1:0][15:0] LOCK_TICKS = {OL_LOCK_TICKS, OH_LOCK_TICKS};

  // ----------------------------------------------------------------
  // Persistence timers: over, under torque, comm, feedback
  // ----------------------------------------------------------------
  localparam int NUM_TIMERS = 4;
  logic [NUM_TIMERS-1:0]       tmr_active;
  logic [NUM_TIMERS-1:0][15:0] tmr_limit;
  logic [NUM_TIMERS-1:0]       tmr_expired;

  persist_if tmr_link [NUM_TIMERS] ();

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_tmr
      assign tmr_link[gi].tick   = s.tick;
      assign tmr_link[gi].active = tmr_active[gi];
      assign tmr_link[gi].limit  = tmr_limit[gi];
      assign tmr_expired[gi]     = tmr_link[gi].expired;
      persist_timer u_timer (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .link       (tmr_link[gi])
      );
    end
  endgenerate

  logic [3:0] ot_action;
  logic [3:0] ut_action;
  logic [3:0] comm_action;
  logic [3:0] fb_sel;
  logic [3:0] ext_sel;
  logic [3:0] stop_sel;

  assign ot_action   = s.sel[SEL_OT_LSB +: 4];
  assign ut_action   = s.sel[SEL_UT_LSB +: 4];
  assign comm_action = s.sel[SEL_COMM_LSB +: 4];
  assign fb_sel      = s.sel[SEL_FB_LSB +: 4];
  assign ext_sel     = s.sel[SEL_EXT_LSB +: 4];
  assign stop_sel    = s.sel[SEL_STOP_LSB +: 4];

  always_comb begin
    tmr_active[0] = (ot_action == OT_ACTION_FAULT) && (torque_in > s.ot_cfg[CFG_LEVEL_LSB +: 16]);
    tmr_active[1] = (ut_action == UT_ACTION_FAULT) && (torque_in < s.ut_cfg[CFG_LEVEL_LSB +: 16]);
    // A frame restarts the silence count
    tmr_active[2] = (comm_action <= COMM_ACTION_MAX) && !frame_rx_in;
    tmr_active[3] = (fb_sel == FB_SEL_FAULT) && (pid_feedback_in < s.fb_cfg[CFG_LEVEL_LSB +: 16]);
    tmr_limit[0]  = s.ot_cfg[CFG_TIME_LSB +: 16];
    tmr_limit[1]  = s.ut_cfg[CFG_TIME_LSB +: 16];
    tmr_limit[2]  = s.comm_cfg[CFG_TIME_LSB +: 16];
    tmr_limit[3]  = s.fb_cfg[CFG_TIME_LSB +: 16];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [NUM_TERMS-1:0][7:0] term_func;
  logic [NUM_FAULTS-1:0]     fault_set;
  logic [NUM_FAULTS-1:0]     fault_clr;
  logic [NUM_FAULTS-1:0]     new_evt;
  logic [NUM_FAULTS-1:0]     irq_clr;
  logic [31:0]               rd_data;
  logic                      mapped;
  logic                      wr_en;
  logic                      reset_req;
  logic                      stop_hit;

  always_comb begin
    next_s    = s;
    term_func = {s.term_hi[15:0], s.term_lo};
    fault_set = '0;
    fault_clr = '0;
    irq_clr   = '0;
    rd_data   = 32'h0000_0000;
    mapped    = 1'b1;
    stop_hit  = 1'b0;

    next_s.term_meta = input_terminal_in;
    next_s.term_sync = s.term_meta;

    if (s.prescale == 22'(TICK_CYCLES - 1)) begin
      next_s.prescale = 22'h000000;
      next_s.tick     = 1'b1;
    end else begin
      next_s.prescale = s.prescale + 22'h000001;
      next_s.tick     = 1'b0;
    end

    // --------------------------------------------------------------
    // APB slave, one wait state so read data leaves a flop
    // --------------------------------------------------------------
    case (paddr_in)
      ADDR_CTRL:    rd_data = 32'h0000_0000;
      ADDR_OT_CFG:  rd_data = s.ot_cfg;
      ADDR_UT_CFG:  rd_data = s.ut_cfg;
      ADDR_FB_CFG:  rd_data = s.fb_cfg;
      ADDR_COMM:    rd_data = s.comm_cfg;
      ADDR_SEL:     rd_data = s.sel;
      ADDR_TERM_LO: rd_data = s.term_lo;
      ADDR_TERM_HI: rd_data = s.term_hi;
      ADDR_FAULT:   rd_data = {18'h00000, s.fault};
      ADDR_CODE:    rd_data = {27'h0000000, s.fault_code};
      ADDR_IRQ_ST:  rd_data = {18'h00000, s.irq_status};
      ADDR_IRQ_CLR: rd_data = 32'h0000_0000;
      ADDR_IRQ_EN:  rd_data = {18'h00000, s.irq_enable};
      ADDR_LOCK:    rd_data = {30'h00000000, s.locked};
      default:      mapped  = 1'b0;
    endcase

    next_s.pready  = psel_in && penable_in && !s.pready;
    next_s.pslverr = psel_in && penable_in && !s.pready && !mapped;
    if (psel_in && penable_in && !s.pready) begin
      next_s.prdata = rd_data;
    end

    wr_en = psel_in && penable_in && s.pready && pwrite_in && mapped;
    if (wr_en) begin
      case (paddr_in)
        ADDR_OT_CFG:  next_s.ot_cfg     = pwdata_in;
        ADDR_UT_CFG:  next_s.ut_cfg     = pwdata_in;
        ADDR_FB_CFG:  next_s.fb_cfg     = pwdata_in;
        ADDR_COMM:    next_s.comm_cfg   = pwdata_in;
        ADDR_SEL:     next_s.sel        = pwdata_in;
        ADDR_TERM_LO: next_s.term_lo    = pwdata_in;
        ADDR_TERM_HI: next_s.term_hi    = {16'h0000, pwdata_in[15:0]};
        ADDR_IRQ_CLR: irq_clr           = pwdata_in[NUM_FAULTS-1:0];
        ADDR_IRQ_EN:  next_s.irq_enable = pwdata_in[NUM_FAULTS-1:0];
        default:      next_s.sel        = s.sel;
      endcase
    end
    reset_req = fault_reset_req_in || (wr_en && (paddr_in == ADDR_CTRL) && pwdata_in[CTRL_RESET_BIT]);

    // --------------------------------------------------------------
    // Fault sources
    // --------------------------------------------------------------
    fault_set[FLT_OH]   = heatsink_overheat_in;
    fault_set[FLT_OL]   = drive_overload_in;
    fault_set[FLT_OT]   = tmr_expired[0];
    fault_set[FLT_UT]   = tmr_expired[1];
    fault_set[FLT_COMM] = tmr_expired[2];
    fault_set[FLT_FB]   = tmr_expired[3];
    for (int i = 0; i < NUM_TERMS; i++) begin
      if (term_func[i] == FUNC_STOP) begin
        stop_hit = 1'b1;
      end
      fault_set[FLT_EXT1 + i] = s.term_sync[i] && (term_func[i] == FUNC_EXT_FAULT)
                                && (ext_sel <= EXT_SEL_MAX);
    end
    fault_set[FLT_STOP]  = (stop_sel == STOP_SEL_ON) && stop_hit;
    fault_set[FLT_MOTOR] = motor_switch_req_in && drive_running_in;

    // Locked faults ignore the reset; a new event wins over a clear
    if (reset_req) begin
      fault_clr         = '1;
      fault_clr[FLT_OH] = !s.locked[0];
      fault_clr[FLT_OL] = !s.locked[1];
    end
    next_s.fault = (s.fault & ~fault_clr) | fault_set;
    new_evt      = fault_set & ~s.fault;

    // --------------------------------------------------------------
    // Repeat-trip lockout; window starts at the first trip
    // --------------------------------------------------------------
    for (int k = 0; k < 2; k++) begin
      if (s.locked[k]) begin
        if (s.tick) begin
          next_s.lock_cnt[k] = s.lock_cnt[k] + 16'h0001;
        end
        if (s.lock_cnt[k] >= LOCK_TICKS[k]) begin
          next_s.locked[k]   = 1'b0;
          next_s.trip_cnt[k] = 3'h0;
          next_s.win_cnt[k]  = 16'h0000;
        end
      end else begin
        if ((s.trip_cnt[k] != 3'h0) && s.tick) begin
          next_s.win_cnt[k] = s.win_cnt[k] + 16'h0001;
        end
        if ((s.trip_cnt[k] != 3'h0) && (s.win_cnt[k] >= WINDOW_TICKS)) begin
          next_s.trip_cnt[k] = 3'h0;
          next_s.win_cnt[k]  = 16'h0000;
        end
        if (new_evt[k]) begin
          if ((s.trip_cnt[k] == 3'h0) || (s.win_cnt[k] >= WINDOW_TICKS)) begin
            next_s.trip_cnt[k] = 3'h1;
            next_s.win_cnt[k]  = 16'h0000;
          end else begin
            next_s.trip_cnt[k] = s.trip_cnt[k] + 3'h1;
          end
          if ((s.trip_cnt[k] + 3'h1 >= TRIP_LIMIT[k]) && (s.win_cnt[k] < WINDOW_TICKS)) begin
            next_s.locked[k]   = 1'b1;
            next_s.lock_cnt[k] = 16'h0000;
          end
        end
      end
    end

    // --------------------------------------------------------------
    // Display code and interrupt
    // --------------------------------------------------------------
    next_s.fault_code = 5'h00;
    for (int j = NUM_FAULTS - 1; j >= 0; j--) begin
      if (next_s.fault[j]) begin
        next_s.fault_code = 5'(j + 1);
      end
    end
    next_s.fault_active = |next_s.fault;
    next_s.irq_status   = (s.irq_status & ~irq_clr) | new_evt;
    next_s.irq          = |(next_s.irq_status & next_s.irq_enable);
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s          <= '0;
      s.ot_cfg   <= CFG_RST;
      s.ut_cfg   <= CFG_RST;
      s.fb_cfg   <= CFG_RST;
      s.comm_cfg <= CFG_RST;
      s.sel      <= SEL_RST;
      s.term_lo  <= TERM_RST;
      s.term_hi  <= TERM_RST;
    end else begin
      s <= next_s;
    end
  end

  assign prdata_out       = s.prdata;
  assign pready_out       = s.pready;
  assign pslverr_out      = s.pslverr;
  assign fault_code_out   = s.fault_code;
  assign fault_active_out = s.fault_active;
  assign irq_out          = s.irq;

endmodule // drive_fault_supervisor

// file: tb/fault_supervisor_asserts.sv
`timescale 1ns/1ps
module fault_supervisor_asserts (
  input wire logic                                         mclk_in,
  input wire logic                                         reset_n_in,
  input wire logic                                         psel_in,
  input wire logic                                         penable_in,
  input wire logic                                         pwrite_in,
  input wire logic [fault_supervisor_pkg::APB_ADDR_W-1:0]  paddr_in,
  input wire logic [31:0]                                  pwdata_in,
  input wire logic [31:0]                                  prdata_out,
  input wire logic                                         pready_out,
  input wire logic                                         pslverr_out,
  input wire logic                                         heatsink_overheat_in,
  input wire logic                                         drive_overload_in,
  input wire logic [15:0]                                  torque_in,
  input wire logic [15:0]                                  pid_feedback_in,
  input wire logic                                         frame_rx_in,
  input wire logic [fault_supervisor_pkg::NUM_TERMS-1:0]   input_terminal_in,
  input wire logic                                         drive_running_in,
  input wire logic                                         motor_switch_req_in,
  input wire logic                                         fault_reset_req_in,
  input wire logic [4:0]                                   fault_code_out,
  input wire logic                                         fault_active_out,
  input wire logic                                         irq_out
);
  import fault_supervisor_pkg::*;
  logic reset_req;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Clear always lands the cycle after the request; the second depth is only slack
  assign reset_req = fault_reset_req_in | (psel_in & penable_in & pwrite_in & pready_out
                     & (paddr_in == ADDR_CTRL) & pwdata_in[CTRL_RESET_BIT]);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  sequence apb_setup;
    psel_in && !penable_in;
  endsequence
  sequence apb_access;
    psel_in && penable_in;
  endsequence
  apb_answer_a: assert property (apb_setup ##1 apb_access |=> pready_out)
    else $error("no answer one cycle after access");
  pready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");
  slverr_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error flag without ready");
  overheat_code_a: assert property (heatsink_overheat_in |=> fault_code_out == 5'h01)
    else $error("overheat not latched with its code");
  overload_code_a: assert property (drive_overload_in |=> fault_active_out && fault_code_out inside {5'h01, 5'h02})
    else $error("overload not latched");
  motor_switch_a: assert property (motor_switch_req_in && drive_running_in |=> fault_active_out)
    else $error("motor change while running not flagged");
  fault_hold_a: assert property ($fell(fault_active_out) |-> $past(reset_req) || $past(reset_req, 2))
    else $error("fault dropped without reset request");
  code_active_a: assert property (fault_active_out == (fault_code_out != 5'h00))
    else $error("code and active flag disagree");
endmodule // fault_supervisor_asserts

bind drive_fault_supervisor fault_supervisor_asserts u_asserts (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .heatsink_overheat_in(heatsink_overheat_in),
  .drive_overload_in(drive_overload_in), .torque_in(torque_in), .pid_feedback_in(pid_feedback_in),
  .frame_rx_in(frame_rx_in), .input_terminal_in(input_terminal_in), .drive_running_in(drive_running_in),
  .motor_switch_req_in(motor_switch_req_in), .fault_reset_req_in(fault_reset_req_in),
  .fault_code_out(fault_code_out), .fault_active_out(fault_active_out), .irq_out(irq_out));

// file: tb/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model #(
  parameter int FRAME_GAP = 2
) (
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  input  wire logic talk_in,
  output logic      frame_rx_out
);
  int gap;
  // ----------------------------------------------------------------
  // Frame pulses
  // ----------------------------------------------------------------
  // Silent host keeps the line low, so no stray frame reaches the device
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gap          <= 0;
      frame_rx_out <= 1'b0;
    end else begin
      gap          <= (gap >= FRAME_GAP - 1) ? 0 : gap + 1;
      frame_rx_out <= talk_in && (gap == 0);
    end
  end
endmodule // serial_host_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import fault_supervisor_pkg::*;
  localparam int TC = 4;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        hot = 1'b0, ovl = 1'b0, run = 1'b0, msw = 1'b0, frq = 1'b0, talk = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [15:0] torque = 16'h0, fbk = 16'h0;
  logic [5:0]  term = 6'h0;
  logic [4:0]  code;
  logic        pready, perr, err, act, irq, frame;
  int          n_mismatch = 0, n_checks = 0, seed = 32'hd233;

  drive_fault_supervisor #(.TICK_CYCLES(TC)) i_dut (
    .mclk_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
    .heatsink_overheat_in(hot), .drive_overload_in(ovl), .torque_in(torque), .pid_feedback_in(fbk),
    .frame_rx_in(frame), .input_terminal_in(term), .drive_running_in(run), .motor_switch_req_in(msw),
    .fault_reset_req_in(frq), .fault_code_out(code), .fault_active_out(act), .irq_out(irq));
  serial_host_model i_host (.mclk_in(clk), .reset_n_in(rst_n), .talk_in(talk), .frame_rx_out(frame));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic int exp_code(input logic on, input int b);
    return on ? b + 1 : 0;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Starts an edge late so psel never changes twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = perr;
    {psel, pen} <= 2'b00;
    if (pready !== 1'b1) begin
      chk(32'(pready), 32'h1);
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic wait_code(input logic [4:0] exp, input int bound);
    int n;
    n = 0;
    while (code !== exp && n < bound) begin
      @(posedge clk);
      n++;
    end
    chk(32'(code), 32'(exp));
    if (code !== exp) end_sim();
  endtask
  task automatic trip(input int which);
    case (which)
      0: hot <= 1'b1;
      1: ovl <= 1'b1;
      2: msw <= 1'b1;
      default: frq <= 1'b1;
    endcase
    cyc(1);
    {hot, ovl, msw, frq} <= 4'h0;
    cyc(3);
  endtask
  task automatic clear;
    trip(3);
    chk(32'({code, act}), 32'h0);
  endtask
  task automatic set_cond(input int idx, input logic on, input logic [15:0] lvl);
    case (idx)
      0: torque <= on ? lvl + 16'h1 : lvl;
      1: torque <= on ? lvl - 16'h1 : lvl;
      2: fbk <= on ? lvl - 16'h1 : lvl;
      default: talk <= !on;
    endcase
  endtask
  // Time 5 ticks; 15 cycles hold at most 4, so a fault means no restart
  task automatic persist(input int idx, input logic [31:0] sel, input int bit_idx);
    logic [15:0] lvl;
    lvl = 16'h0100 + 16'($random(seed) & 32'h7fff);
    set_cond(idx, 1'b0, lvl);
    wr(ADDR_OT_CFG + 8'(4 * idx), {16'h0005, lvl});
    wr(ADDR_SEL, sel);
    set_cond(idx, 1'b1, lvl);
    cyc(15);
    set_cond(idx, 1'b0, lvl);
    cyc(4);
    set_cond(idx, 1'b1, lvl);
    cyc(15);
    chk(32'(code), 32'h0);
    wait_code(5'(bit_idx + 1), 40);
    set_cond(idx, 1'b0, lvl);
    wr(ADDR_SEL, SEL_RST);
    clear();
  endtask
  task automatic lock_test(input int which, input int limit, input int lock);
    for (int i = 1; i <= limit; i++) begin
      trip(which);
      wr(ADDR_CTRL, 32'h1);
      cyc(2);
      chk(32'(code), exp_code(i == limit, which));
    end
    apb(1'b0, ADDR_LOCK, 32'h0, r);
    chk(r, 32'h1 << which);
    cyc(lock * TC - 300);
    trip(3);
    chk(32'(code), 32'(which + 1));
    cyc(600);
    clear();
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    cyc(4);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_SEL, 32'h0, r);
    chk(r, SEL_RST);
    apb(1'b0, 8'hfc, 32'h0, r);
    chk({r[30:0], err}, 32'h1);
    wr(ADDR_FAULT, 32'hffff_ffff);
    apb(1'b0, ADDR_FAULT, 32'h0, r);
    chk(r, 32'h0);
    run <= 1'b1;
    wr(ADDR_IRQ_EN, 32'h1 << FLT_MOTOR);
    trip(2);
    chk({26'h0, code, irq}, {26'h0, 5'(FLT_MOTOR + 1), 1'b1});
    wr(ADDR_IRQ_EN, 32'h0);
    cyc(2);
    chk(32'(irq), 32'h0);
    clear();
    wr(ADDR_IRQ_EN, 32'h1 << FLT_MOTOR);
    cyc(2);
    chk(32'(irq), 32'h1);
    wr(ADDR_IRQ_CLR, 32'h1 << FLT_MOTOR);
    cyc(2);
    chk(32'(irq), 32'h0);
    run <= 1'b0;
    trip(2);
    chk(32'(code), 32'h0);
    persist(0, 32'h0012_0310, FLT_OT);
    persist(1, 32'h0012_0301, FLT_UT);
    persist(2, 32'h0012_2311, FLT_FB);
    for (int a = 0; a < 3; a++) persist(3, 32'h0012_0011 | (32'(a) << 8), FLT_COMM);
    talk <= 1'b0;
    cyc(40);
    chk(32'(code), 32'h0);
    talk <= 1'b1;
    wr(ADDR_TERM_LO, 32'h1919_1919);
    wr(ADDR_TERM_HI, 32'h0000_1919);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_SEL, 32'h0010_0311 | (32'(k) << 16));
      for (int t = 0; t < 6; t++) begin
        term <= (6'h1 << t) | 6'(6'($random(seed)) << (t + 1));
        cyc(5);
        chk(32'(code), exp_code(k < 2, FLT_EXT1 + t));
        term <= 6'h0;
        cyc(4);
        chk(32'(code), exp_code(k < 2, FLT_EXT1 + t));
        clear();
      end
    end
    wr(ADDR_TERM_LO, 32'h0);
    wr(ADDR_TERM_HI, 32'h0000_3a00);
    wr(ADDR_SEL, 32'h0002_0311);
    wait_code(5'(FLT_STOP + 1), 10);
    wr(ADDR_SEL, SEL_RST);
    clear();
    lock_test(0, 3, 6000);
    lock_test(1, 4, 2400);
    end_sim();
  end
endmodule // testbench
